// file: rtl/tcs_defs.svh
// Register offsets, field positions, reset values and widths of the timer channel block
`ifndef TCS_DEFS_SVH
`define TCS_DEFS_SVH

`define TCS_OFF_GATE 4'h0
`define TCS_OFF_PSC 4'h1
`define TCS_OFF_MODE_HI 4'h2
`define TCS_OFF_MODE_LO 4'h3
`define TCS_OFF_RELOAD_LO 4'h4
`define TCS_OFF_RELOAD_HI 4'h5
`define TCS_OFF_CAPT_LO 4'h6
`define TCS_OFF_CAPT_HI 4'h7
`define TCS_OFF_CNT_LO 4'h8
`define TCS_OFF_CNT_HI 4'h9
`define TCS_OFF_CTRL 4'ha
`define TCS_OFF_STATUS 4'hb

`define TCS_GATE_BIT 0
`define TCS_PSC0_LSB 0
`define TCS_PSC1_LSB 4
`define TCS_CTRL_START_BIT 0
`define TCS_CTRL_STOP_BIT 1

`define TCS_MASK_GATE 8'h01
`define TCS_MASK_MODE_HI 8'h97
`define TCS_MASK_MODE_LO 8'hcf

`define TCS_RST_GATE 8'h00
`define TCS_RST_PSC 8'h00
`define TCS_RST_MODE_HI 8'h00
`define TCS_RST_MODE_LO 8'h00
`define TCS_RST_RELOAD 16'h0000

`define TCS_PSC_W 15

`endif

// file: rtl/tcs_pkg.sv
// Types shared by the timer channel block
package tcs_pkg;

   typedef logic [15:0] tcs_cnt_t;

   typedef struct packed {
      logic op_clk_sel;
      logic [1:0] rsvd_hi;
      logic count_clk_sel;
      logic rsvd_lo;
      logic [2:0] start_trigger;
   } tcs_mode_hi_s;

   typedef struct packed {
      logic [1:0] input_edge;
      logic [1:0] rsvd;
      logic [2:0] mode;
      logic mode_lsb;
   } tcs_mode_lo_s;

   typedef enum logic [2:0] {
      TCS_MD_INTERVAL = 3'h0,
      TCS_MD_CAPTURE = 3'h2,
      TCS_MD_EVENT = 3'h3,
      TCS_MD_ONECOUNT = 3'h4,
      TCS_MD_CAPONE = 3'h6
   } tcs_mode_e;

   typedef enum logic [1:0] {
      TCS_EDGE_FALL = 2'h0,
      TCS_EDGE_RISE = 2'h1,
      TCS_EDGE_LOW_W = 2'h2,
      TCS_EDGE_HIGH_W = 2'h3
   } tcs_edge_e;

   typedef enum logic [2:0] {
      TCS_ST_IDLE = 3'b001,
      TCS_ST_COUNT = 3'b010,
      TCS_ST_WAIT = 3'b100
   } tcs_state_e;

endpackage : tcs_pkg

// file: rtl/tcs_prescale_tap.sv
// One power-of-two tap of the shared prescaler counter
`timescale 1ns/1ns
module tcs_prescale_tap
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic run,
   input wire logic [14:0] psc_cnt,
   input wire logic [3:0] sel,
   output logic tick_q
);
   logic [15:0] low_mask;
   logic hit;

   // Low sel bits all ones once every 2^sel cycles; sel 0 hits every cycle
   assign low_mask = (16'h0001 << sel) - 16'h0001;
   assign hit = &(psc_cnt | ~low_mask[14:0]);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         tick_q <= 1'b0;
      else
         tick_q <= run & hit;
   end
endmodule : tcs_prescale_tap

// file: rtl/tcs_timer.sv
// Timer channel 0 with clock gate, prescaler, count clock and mode selection
//
// Summary of operation
// R1 - Unit clock runs only while gate bit set
// R2 - First prescaled clock is sysclk over 2^field
// R3 - Op clock select picks first or second prescaler
// R4 - Count clock: operation clock or valid pin edges
// R5 - Edge field: fall, rise, or both split
// R6 - Mode 000 interval timer, counts down
// R7 - Mode 010 capture, counts up
// R8 - Mode 011 event counter, counts down
// R9 - Mode 100 one-count, counts down
// R10 - Mode 110 capture one-count, counts up
// R11 - Software selects software start trigger
// R12 - Lowest mode bit raises event at start in modes 000 and 010
// R13 - Software avoids prohibited mode codes
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/1ns
`include "tcs_defs.svh"
module tcs_timer
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata_q,
   input wire logic timer_input_pin,
   output logic tmr_event_q,
   output logic tmr_running_q
);
   logic rst_s1_q;
   logic rst_n_q;
   logic [7:0] gate_q;
   logic [7:0] psc_q;
   tcs_pkg::tcs_mode_hi_s mode_hi_q;
   tcs_pkg::tcs_mode_lo_s mode_lo_q;
   tcs_pkg::tcs_cnt_t reload_q;
   tcs_pkg::tcs_cnt_t capt_q;
   tcs_pkg::tcs_cnt_t capt_d;
   tcs_pkg::tcs_cnt_t channel_counter_q;
   tcs_pkg::tcs_cnt_t channel_counter_d;
   tcs_pkg::tcs_state_e state_q;
   tcs_pkg::tcs_state_e state_d;
   logic event_d;
   logic [`TCS_PSC_W-1:0] psc_cnt_q;
   logic pin_s1_q;
   logic pin_s2_q;
   logic pin_s3_q;

   // Reset released through two flops so every flop leaves reset on one edge
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rst_s1_q <= 1'b0;
         rst_n_q <= 1'b0;
      end
      else
      begin
         rst_s1_q <= 1'b1;
         rst_n_q <= rst_s1_q;
      end
   end

   // Register decode
   logic wr_gate;
   logic wr_psc;
   logic wr_mode_hi;
   logic wr_mode_lo;
   logic wr_rel_lo;
   logic wr_rel_hi;
   logic sw_start;
   logic sw_stop;
   assign wr_gate = wr && (addr == `TCS_OFF_GATE);
   assign wr_psc = wr && (addr == `TCS_OFF_PSC);
   assign wr_mode_hi = wr && (addr == `TCS_OFF_MODE_HI);
   assign wr_mode_lo = wr && (addr == `TCS_OFF_MODE_LO);
   assign wr_rel_lo = wr && (addr == `TCS_OFF_RELOAD_LO);
   assign wr_rel_hi = wr && (addr == `TCS_OFF_RELOAD_HI);
   assign sw_start = wr && (addr == `TCS_OFF_CTRL) && wdata[`TCS_CTRL_START_BIT];
   assign sw_stop = wr && (addr == `TCS_OFF_CTRL) && wdata[`TCS_CTRL_STOP_BIT];

   always_ff @(posedge clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         gate_q <= `TCS_RST_GATE;
         psc_q <= `TCS_RST_PSC;
         mode_hi_q <= `TCS_RST_MODE_HI;
         mode_lo_q <= `TCS_RST_MODE_LO;
         reload_q <= `TCS_RST_RELOAD;
      end
      else
      begin
         if (wr_gate)
            gate_q <= wdata & `TCS_MASK_GATE;
         if (wr_psc)
            psc_q <= wdata;
         if (wr_mode_hi)
            mode_hi_q <= wdata & `TCS_MASK_MODE_HI;
         if (wr_mode_lo)
            mode_lo_q <= wdata & `TCS_MASK_MODE_LO;
         if (wr_rel_lo)
            reload_q[7:0] <= wdata;
         if (wr_rel_hi)
            reload_q[15:8] <= wdata;
      end
   end

   // Unit clock gate: while it is clear the prescaler freezes and the channel changes only on a stop
   logic unit_en;
   assign unit_en = gate_q[`TCS_GATE_BIT]; // R1

   always_ff @(posedge clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
         psc_cnt_q <= '0;
      else if (unit_en) // R1
         psc_cnt_q <= psc_cnt_q + 15'h0001;
   end

   logic tick0;
   logic tick1;

   tcs_prescale_tap u_first_prescaler
   (
      .clk(clk),
      .rst_n(rst_n_q),
      .run(unit_en),
      .psc_cnt(psc_cnt_q),
      .sel(psc_q[`TCS_PSC0_LSB +: 4]),
      .tick_q(tick0)
   ); // R2

   // Second divider uses the same power-of-two law as the first
   tcs_prescale_tap u_second_prescaler
   (
      .clk(clk),
      .rst_n(rst_n_q),
      .run(unit_en),
      .psc_cnt(psc_cnt_q),
      .sel(psc_q[`TCS_PSC1_LSB +: 4]),
      .tick_q(tick1)
   );

   logic op_tick;
   assign op_tick = mode_hi_q.op_clk_sel ? tick1 : tick0; // R3

   // Pin synchroniser; edges are taken only after the second stage
   always_ff @(posedge clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         pin_s1_q <= 1'b0;
         pin_s2_q <= 1'b0;
         pin_s3_q <= 1'b0;
      end
      else
      begin
         pin_s1_q <= timer_input_pin;
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
      end
   end

   logic pin_rise;
   logic pin_fall;
   logic cnt_edge;
   logic start_edge;
   logic cap_edge;
   tcs_pkg::tcs_edge_e edge_sel;
   assign pin_rise = unit_en && pin_s2_q && !pin_s3_q;
   assign pin_fall = unit_en && !pin_s2_q && pin_s3_q;
   assign edge_sel = tcs_pkg::tcs_edge_e'(mode_lo_q.input_edge);
   assign cnt_edge = (edge_sel == tcs_pkg::TCS_EDGE_FALL) ? pin_fall :
                     (edge_sel == tcs_pkg::TCS_EDGE_RISE) ? pin_rise :
                     (pin_rise | pin_fall); // R5
   assign start_edge = (edge_sel == tcs_pkg::TCS_EDGE_LOW_W) ? pin_fall :
                       (edge_sel == tcs_pkg::TCS_EDGE_HIGH_W) ? pin_rise : cnt_edge; // R5
   assign cap_edge = (edge_sel == tcs_pkg::TCS_EDGE_LOW_W) ? pin_rise :
                     (edge_sel == tcs_pkg::TCS_EDGE_HIGH_W) ? pin_fall : cnt_edge; // R5

   logic cnt_tick;
   assign cnt_tick = unit_en && (mode_hi_q.count_clk_sel ? cnt_edge : op_tick); // R4

   // Mode decode
   logic [2:0] md;
   logic md_lsb;
   logic is_interval;
   logic is_capture;
   logic is_event;
   logic is_onecount;
   logic is_capone;
   logic is_down;
   logic mode_ok;
   logic ext_trig;
   logic one_trig;
   logic start_evt;
   assign md = mode_lo_q.mode;
   assign md_lsb = mode_lo_q.mode_lsb;
   assign is_interval = (md == tcs_pkg::TCS_MD_INTERVAL); // R6
   assign is_capture = (md == tcs_pkg::TCS_MD_CAPTURE); // R7
   assign is_event = (md == tcs_pkg::TCS_MD_EVENT); // R8
   assign is_onecount = (md == tcs_pkg::TCS_MD_ONECOUNT); // R9
   assign is_capone = (md == tcs_pkg::TCS_MD_CAPONE); // R10
   assign is_down = is_interval | is_event | is_onecount;
   // Prohibited codes never start from idle; there the channel stays put
   assign mode_ok = is_down | is_capture | is_capone; // R13
   // A non-zero start trigger code lets the pin start edge trigger
   assign ext_trig = (mode_hi_q.start_trigger != 3'h0) && start_edge;
   assign one_trig = sw_start | ext_trig | (is_capone & start_edge);
   assign start_evt = md_lsb && (is_interval | is_capture); // R12

   // Channel sequencing
   always_comb
   begin
      state_d = state_q;
      channel_counter_d = channel_counter_q;
      capt_d = capt_q;
      event_d = 1'b0;
      if (sw_stop)
         state_d = tcs_pkg::TCS_ST_IDLE;
      else if (unit_en) // R1
      begin
         case (state_q)
            tcs_pkg::TCS_ST_IDLE:
            begin
               if (sw_start && mode_ok) // R13
               begin
                  if (is_onecount | is_capone)
                     state_d = tcs_pkg::TCS_ST_WAIT;
                  else
                  begin
                     state_d = tcs_pkg::TCS_ST_COUNT;
                     channel_counter_d = is_capture ? 16'h0000 : reload_q;
                     event_d = start_evt; // R12
                  end
               end
            end
            tcs_pkg::TCS_ST_WAIT:
            begin
               if (one_trig)
               begin
                  state_d = tcs_pkg::TCS_ST_COUNT;
                  channel_counter_d = is_capone ? 16'h0000 : reload_q;
               end
            end
            tcs_pkg::TCS_ST_COUNT:
            begin
               if (is_interval | is_event)
               begin
                  if (cnt_tick) // R6 R8
                  begin
                     if (channel_counter_q == 16'h0000)
                     begin
                        channel_counter_d = reload_q;
                        event_d = 1'b1;
                     end
                     else
                        channel_counter_d = channel_counter_q - 16'h0001;
                  end
               end
               else if (is_capture)
               begin
                  if (cap_edge) // R7
                  begin
                     capt_d = channel_counter_q;
                     channel_counter_d = 16'h0000;
                     event_d = 1'b1;
                  end
                  else if (cnt_tick)
                     channel_counter_d = channel_counter_q + 16'h0001;
               end
               else if (is_onecount)
               begin
                  // Retrigger while counting only when the lowest mode bit is set
                  if (one_trig && md_lsb) // R9
                  begin
                     channel_counter_d = reload_q;
                     event_d = 1'b1;
                  end
                  else if (cnt_tick)
                  begin
                     if (channel_counter_q == 16'h0000)
                     begin
                        event_d = 1'b1;
                        state_d = tcs_pkg::TCS_ST_WAIT;
                     end
                     else
                        channel_counter_d = channel_counter_q - 16'h0001;
                  end
               end
               else if (is_capone)
               begin
                  if (cap_edge) // R10
                  begin
                     capt_d = channel_counter_q;
                     event_d = 1'b1;
                     state_d = tcs_pkg::TCS_ST_WAIT;
                  end
                  else if (cnt_tick)
                     channel_counter_d = channel_counter_q + 16'h0001;
               end
            end
            default:
               state_d = tcs_pkg::TCS_ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         state_q <= tcs_pkg::TCS_ST_IDLE;
         channel_counter_q <= 16'h0000;
         capt_q <= 16'h0000;
         tmr_event_q <= 1'b0;
         tmr_running_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         channel_counter_q <= channel_counter_d;
         capt_q <= capt_d;
         tmr_event_q <= event_d;
         tmr_running_q <= (state_d == tcs_pkg::TCS_ST_COUNT);
      end
   end

   // Read selection; unmapped offsets read zero
   logic [7:0] status;
   logic [7:0] rd_mux;
   assign status = {5'h00, ~is_down, state_q == tcs_pkg::TCS_ST_WAIT,
                    state_q == tcs_pkg::TCS_ST_COUNT};
   assign rd_mux = (addr == `TCS_OFF_GATE) ? gate_q :
                   (addr == `TCS_OFF_PSC) ? psc_q :
                   (addr == `TCS_OFF_MODE_HI) ? mode_hi_q :
                   (addr == `TCS_OFF_MODE_LO) ? mode_lo_q :
                   (addr == `TCS_OFF_RELOAD_LO) ? reload_q[7:0] :
                   (addr == `TCS_OFF_RELOAD_HI) ? reload_q[15:8] :
                   (addr == `TCS_OFF_CAPT_LO) ? capt_q[7:0] :
                   (addr == `TCS_OFF_CAPT_HI) ? capt_q[15:8] :
                   (addr == `TCS_OFF_CNT_LO) ? channel_counter_q[7:0] :
                   (addr == `TCS_OFF_CNT_HI) ? channel_counter_q[15:8] :
                   (addr == `TCS_OFF_STATUS) ? status : 8'h00;

   // Counter bytes are read live; software must tolerate a carry between reads
   always_ff @(posedge clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
         rdata_q <= 8'h00;
      else
         rdata_q <= rd ? rd_mux : 8'h00;
   end
endmodule : tcs_timer

// file: verification/tcs_timer_assertions.sv
// Port-level checker for the timer channel, bound to its top module
`timescale 1ns/1ns
`include "tcs_defs.svh"
module tcs_timer_chk
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata_q,
   input wire logic timer_input_pin,
   input wire logic tmr_event_q,
   input wire logic tmr_running_q
);
   logic gate_q;
   logic [7:0] mode_hi_q;
   logic [7:0] mode_lo_q;
   wire logic is_ctrl = wr && addr == `TCS_OFF_CTRL;
   wire logic start_evt_mode = mode_lo_q[3:1] == 3'h0 || mode_lo_q[3:1] == 3'h2;

   // Shadow of the configuration software has written
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         gate_q <= 1'b0;
         mode_hi_q <= 8'h00;
         mode_lo_q <= 8'h00;
      end
      else if (wr)
      begin
         if (addr == `TCS_OFF_GATE)
            gate_q <= wdata[0];
         if (addr == `TCS_OFF_MODE_HI)
            mode_hi_q <= wdata;
         if (addr == `TCS_OFF_MODE_LO)
            mode_lo_q <= wdata;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   sequence s_start;
      is_ctrl && wdata[1:0] == 2'b01;
   endsequence
   sequence s_idle_start;
      !tmr_running_q ##0 s_start;
   endsequence

   property p_gated_quiet;
      !gate_q [*4] |-> !tmr_event_q;
   endproperty
   property p_gated_start;
      !gate_q ##0 s_idle_start |=> !tmr_running_q;
   endproperty
   property p_gate_rb;
      rd && addr == `TCS_OFF_GATE |=> rdata_q == {7'h00, gate_q};
   endproperty
   property p_start_event;
      gate_q && start_evt_mode ##0 s_idle_start |=> tmr_running_q && tmr_event_q == mode_lo_q[0];
   endproperty
   property p_stop;
      is_ctrl && wdata[1] |=> !tmr_running_q;
   endproperty
   property p_rdata_idle;
      !rd |=> rdata_q == 8'h00;
   endproperty
   property p_mode_hi_rb;
      rd && addr == `TCS_OFF_MODE_HI |=> rdata_q == (mode_hi_q & `TCS_MASK_MODE_HI);
   endproperty
   property p_mode_lo_rb;
      rd && addr == `TCS_OFF_MODE_LO |=> rdata_q == (mode_lo_q & `TCS_MASK_MODE_LO);
   endproperty
   property p_unmapped;
      rd && addr > `TCS_OFF_STATUS |=> rdata_q == 8'h00;
   endproperty

   a_gated_quiet: assert property (p_gated_quiet)
      else $error("event while unit clock gated");
   a_gated_start: assert property (p_gated_start)
      else $error("start accepted while gated");
   a_gate_rb: assert property (p_gate_rb)
      else $error("gate register readback wrong");
   a_start_event: assert property (p_start_event)
      else $error("start event does not follow mode lsb");
   a_stop: assert property (p_stop)
      else $error("channel still running after stop");
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data not zero outside read");
   a_mode_hi_rb: assert property (p_mode_hi_rb)
      else $error("mode upper readback wrong");
   a_mode_lo_rb: assert property (p_mode_lo_rb)
      else $error("mode lower readback wrong");
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
endmodule : tcs_timer_chk

bind tcs_timer tcs_timer_chk i_tcs_timer_chk (.clk(clk), .resetn(resetn), .addr(addr),
   .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q), .timer_input_pin(timer_input_pin),
   .tmr_event_q(tmr_event_q), .tmr_running_q(tmr_running_q));

// file: verification/tcs_pin_src.sv
// Pulse source standing in for the external signal on the timer input pin
`timescale 1ns/1ns
module tcs_pin_src
#(
   parameter int EDGES = 4,
   parameter int GAP = 4
)
(
   input wire logic clk,
   input wire logic go,
   output logic pin,
   output logic busy
);
   logic pin_q = 1'b1;
   int left = 0;
   int wait_q = 0;
   assign pin = pin_q;
   assign busy = left != 0;
   // Edges spaced well apart so the synchroniser sees each one
   always @(posedge clk)
   begin
      if (go && left == 0)
      begin
         left <= EDGES;
         wait_q <= GAP;
      end
      else if (left != 0 && wait_q != 0)
         wait_q <= wait_q - 1;
      else if (left != 0)
      begin
         pin_q <= ~pin_q;
         left <= left - 1;
         wait_q <= GAP;
      end
   end
endmodule : tcs_pin_src

// file: verification/testbench.sv
// Self-checking bench for the timer channel
`timescale 1ns/1ns
`include "tcs_defs.svh"
module testbench;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic rd_d = 1'b0;
   logic go = 1'b0;
   logic [7:0] rdata_q;
   logic pin;
   logic busy;
   logic tmr_event_q;
   logic tmr_running_q;
   logic [7:0] exp_q[$];
   int miscompares = 0;
   int cmp_count = 0;
   int n;
   logic [7:0] d;
   logic [7:0] masks[4] = '{`TCS_MASK_GATE, 8'hff, `TCS_MASK_MODE_HI, `TCS_MASK_MODE_LO};
   logic [7:0] p_hi[4] = '{8'h00, 8'h00, 8'h80, 8'h00};
   logic [7:0] p_psc[4] = '{8'h00, 8'h03, 8'h21, 8'h0f};
   logic [7:0] p_rl[4] = '{8'h05, 8'h05, 8'h05, 8'h00};
   int p_sh[4] = '{0, 3, 2, 15};
   logic [2:0] md[5] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h6};
   logic [7:0] st[5] = '{8'h01, 8'h05, 8'h01, 8'h02, 8'h06};
   logic [7:0] cn[5] = '{8'h0b, 8'h05, 8'h0b, 8'h0f, 8'h01};

   tcs_timer i_tcs_timer (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata_q(rdata_q), .timer_input_pin(pin), .tmr_event_q(tmr_event_q),
      .tmr_running_q(tmr_running_q));
   tcs_pin_src i_tcs_pin_src (.clk(clk), .go(go), .pin(pin), .busy(busy));

   always #10 clk = ~clk;

   task give_verdict;
      if (miscompares == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : give_verdict

   task check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task wr_reg(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   task rd_exp(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      exp_q.push_back(e);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
   endtask : rd_exp

   // Read data stand only in the cycle after the strobe
   always @(posedge clk)
   begin
      if (rd_d)
         check(rdata_q, exp_q.pop_front());
      rd_d <= rd;
   end

   task wait_ev(output int k);
      k = 0;
      do
      begin
         @(posedge clk);
         k++;
      end
      while (tmr_event_q !== 1'b1 && k < 40000);
      if (k >= 40000)
      begin
         miscompares++;
         give_verdict();
      end
   endtask : wait_ev

   task cfg(input logic [7:0] g, input logic [7:0] p, input logic [7:0] h,
      input logic [7:0] l, input logic [7:0] r);
      wr_reg(`TCS_OFF_GATE, g);
      wr_reg(`TCS_OFF_PSC, p);
      wr_reg(`TCS_OFF_MODE_HI, h);
      wr_reg(`TCS_OFF_MODE_LO, l);
      wr_reg(`TCS_OFF_RELOAD_LO, r);
      wr_reg(`TCS_OFF_RELOAD_HI, 8'h00);
      wr_reg(`TCS_OFF_CTRL, 8'h01);
   endtask : cfg

   initial
   begin
      n = $urandom(39);
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      for (int a = 0; a < 4; a++)
         rd_exp(4'(a), 8'h00);
      for (int a = 0; a < 4; a++)
      begin
         d = 8'($urandom);
         if (a == 3)
            d[3:1] = 3'h4;
         wr_reg(4'(a), d);
         rd_exp(4'(a), d & masks[a]);
      end
      rd_exp(4'he, 8'h00);
      rd_exp(`TCS_OFF_CTRL, 8'h00);
      // Start refused while the unit clock is gated
      cfg(8'h00, 8'h00, 8'h00, 8'h00, 8'h10);
      rd_exp(`TCS_OFF_STATUS, 8'h00);
      for (int i = 0; i < 4; i++)
      begin
         cfg(8'h01, p_psc[i], p_hi[i], 8'h00, p_rl[i]);
         wait_ev(n);
         wait_ev(n);
         check(n, 32'((p_rl[i] + 1) << p_sh[i]));
         if (i == 0)
         begin
            // Gate drops mid-count; the tick in the write cycle still lands
            wr_reg(`TCS_OFF_GATE, 8'h00);
            rd_exp(`TCS_OFF_CNT_LO, 8'h02);
         end
         wr_reg(`TCS_OFF_CTRL, 8'h02);
      end
      for (int m = 0; m < 4; m += 3)
         for (int e = 0; e < 4; e++)
         begin
            cfg(8'h01, 8'h00, 8'h10, 8'(e * 64 + m * 2), 8'h10);
            go <= 1'b1;
            @(posedge clk);
            go <= 1'b0;
            @(posedge clk);
            n = 0;
            while (busy && n < 100)
            begin
               @(posedge clk);
               n++;
            end
            check(n < 100, 1'b1);
            if (n >= 100)
               give_verdict();
            repeat (8) @(posedge clk);
            rd_exp(`TCS_OFF_CNT_LO, (e < 2) ? 8'h0e : 8'h0c);
            rd_exp(`TCS_OFF_CNT_HI, 8'h00);
            wr_reg(`TCS_OFF_CTRL, 8'h02);
         end
      for (int i = 0; i < 5; i++)
      begin
         cfg(8'h01, 8'h00, 8'h00, {4'h0, md[i], md[i] == 3'h0 || md[i] == 3'h2}, 8'h10);
         rd_exp(`TCS_OFF_STATUS, st[i]);
         // Second start triggers the waiting modes; counting modes ignore it
         wr_reg(`TCS_OFF_CTRL, 8'h01);
         rd_exp(`TCS_OFF_CNT_LO, cn[i]);
         wr_reg(`TCS_OFF_CTRL, 8'h02);
      end
      repeat (4) @(posedge clk);
      give_verdict();
   end
endmodule : testbench
